// >>> rtl/demod_cfg_if.sv
// Purpose: carries raw configuration fields from bank to datapath
// Assumes: single clock domain
// Notes: bank drives, datapath consumes
`timescale 1ns/10ps
`default_nettype none
interface demod_cfg_if;
  logic [1:0] post_detect_average;
  logic [2:0] detector_bandwidth_sel;
  logic [2:0] detector_gain;
  logic [7:0] four_level_threshold;
  logic [7:0] rx_deviation_range;
  logic [7:0] afc_track_range;
  logic afc_limiter_disable;
  logic [2:0] synth_correction_shift;
  logic [7:0] synth_correction_coef;
  modport bank (output post_detect_average, detector_bandwidth_sel, detector_gain, four_level_threshold,
    rx_deviation_range, afc_track_range, afc_limiter_disable, synth_correction_shift, synth_correction_coef);
  modport user (input post_detect_average, detector_bandwidth_sel, detector_gain, four_level_threshold,
    rx_deviation_range, afc_track_range, afc_limiter_disable, synth_correction_shift, synth_correction_coef);
endinterface
`default_nettype wire

// >>> rtl/demod_cfg_pkg.sv
// Purpose: constants shared by the demodulator configuration bank
// Assumes: one clock domain, 8-bit register port
// Notes: offsets are bank-local byte addresses
package demod_cfg_pkg;
  localparam int REG_W = 8;
  localparam int ADDR_W = 8;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FILTER = 8'h57;
  localparam logic [7:0] OFS_GAIN = 8'h58;
  localparam logic [7:0] OFS_THRESH = 8'h59;
  localparam logic [7:0] OFS_RSVD_A = 8'h5A;
  localparam logic [7:0] OFS_RSVD_B = 8'h5B;
  localparam logic [7:0] OFS_RXDEV = 8'h5C;
  localparam logic [7:0] OFS_AFCLIM = 8'h5D;
  localparam logic [7:0] OFS_SHIFT = 8'h5E;
  localparam logic [7:0] OFS_COEF = 8'h5F;
  localparam int NUM_REGS = 9;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_FILTER = 8'h04;
  localparam logic [7:0] RST_GAIN = 8'h01;
  localparam logic [7:0] RST_THRESH = 8'h14;
  localparam logic [7:0] RST_RSVD = 8'h00;
  localparam logic [7:0] RST_RXDEV = 8'h12;
  localparam logic [7:0] RST_AFCLIM = 8'h0D;
  localparam logic [7:0] RST_SHIFT = 8'h05;
  localparam logic [7:0] RST_COEF = 8'h6C;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int AVG_LSB = 4;
  localparam int AVG_MSB = 5;
  localparam int BW_MSB = 2;
  localparam int GAIN_MSB = 2;
  localparam int SHIFT_MSB = 2;
  // averaging codes and shift amounts
  typedef enum logic [1:0] {
    AVG_NONE = 2'b00,
    AVG_TWO = 2'b01,
    AVG_FOUR = 2'b10,
    AVG_EIGHT = 2'b11
  } avg_mode_t;
  // bandwidth factor as numerator over common denominator 600
  localparam int BW_DEN = 600;
endpackage

// >>> rtl/demod_config_regs.sv
// Purpose: demodulator configuration register bank and field decode
// Assumes: 8-bit register port synchronous to clk_sys, one access per cycle
// Notes: read data registered, valid one cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
module demod_config_regs
  import demod_cfg_pkg::*;
(
  input wire logic clk_sys, // system clock, 200 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr, // bank-local register offset
  input wire logic [7:0] reg_wdata, // write data
  input wire logic afc_limiter_disable, // limiter-disable bit from neighbour register
  output logic [7:0] reg_rdata, // read data
  output logic reg_rvalid, // read data valid pulse
  output logic [1:0] post_detect_average, // averaging code
  output logic [2:0] detector_bandwidth_sel, // bandwidth code
  output logic [2:0] detector_gain, // gain code
  output logic [7:0] four_level_threshold, // four-level threshold
  output logic [7:0] rx_deviation_range, // deviation range value
  output logic [7:0] afc_track_range, // afc tracking range value
  output logic [2:0] synth_correction_shift, // first magnification
  output logic [7:0] synth_correction_coef, // second coefficient
  output logic [2:0] avg_shift, // decoded averaging shift
  output logic [5:0] bw_num, // decoded bandwidth numerator over 600
  output logic [3:0] gain_x2, // decoded twice gain
  output logic [7:0] afc_limit, // effective afc limit
  output logic afc_limit_en // afc limiter active
);
  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] regs;
    logic [7:0] rdata;
    logic rvalid;
  } bank_state_t;
  bank_state_t st, next_st;

  localparam logic [NUM_REGS-1:0][7:0] OFFSETS = {OFS_COEF, OFS_SHIFT, OFS_AFCLIM, OFS_RXDEV,
    OFS_RSVD_B, OFS_RSVD_A, OFS_THRESH, OFS_GAIN, OFS_FILTER};
  localparam logic [NUM_REGS-1:0][7:0] RESETS = {RST_COEF, RST_SHIFT, RST_AFCLIM, RST_RXDEV,
    RST_RSVD, RST_RSVD, RST_THRESH, RST_GAIN, RST_FILTER};

  logic [NUM_REGS-1:0] hit;
  logic [NUM_REGS-1:0][7:0] masked;

  // address match per register
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi = gi + 1) begin : g_dec
      assign hit[gi] = (reg_addr == OFFSETS[gi]);
      assign masked[gi] = hit[gi] ? st.regs[gi] : 8'h00;
    end
  endgenerate

  // next-state: writes, read mux
  always_comb begin
    logic [7:0] rd;
    rd = 8'h00;
    next_st = st;
    for (int i = 0; i < NUM_REGS; i++) begin
      rd = rd | masked[i];
      if (reg_wr && hit[i]) begin
        next_st.regs[i] = reg_wdata;
      end
    end
    next_st.rvalid = reg_rd;
    next_st.rdata = reg_rd ? rd : 8'h00; // unmapped reads give zero
  end

  // register the bank
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st.regs <= RESETS;
      st.rdata <= 8'h00;
      st.rvalid <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // field outputs, straight from flip-flops
  // ----------------------------------------------------------------
  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign post_detect_average = st.regs[0][AVG_MSB:AVG_LSB];
  assign detector_bandwidth_sel = st.regs[0][BW_MSB:0];
  assign detector_gain = st.regs[1][GAIN_MSB:0];
  assign four_level_threshold = st.regs[2];
  assign rx_deviation_range = st.regs[5];
  assign afc_track_range = st.regs[6];
  assign synth_correction_shift = st.regs[7][SHIFT_MSB:0];
  assign synth_correction_coef = st.regs[8];

  // ----------------------------------------------------------------
  // decode for the datapath
  // ----------------------------------------------------------------
  demod_cfg_if cfg_bus ();
  assign cfg_bus.post_detect_average = post_detect_average;
  assign cfg_bus.detector_bandwidth_sel = detector_bandwidth_sel;
  assign cfg_bus.detector_gain = detector_gain;
  assign cfg_bus.four_level_threshold = four_level_threshold;
  assign cfg_bus.rx_deviation_range = rx_deviation_range;
  assign cfg_bus.afc_track_range = afc_track_range;
  assign cfg_bus.afc_limiter_disable = afc_limiter_disable;
  assign cfg_bus.synth_correction_shift = synth_correction_shift;
  assign cfg_bus.synth_correction_coef = synth_correction_coef;

  demod_param_decode u_decode (
    .clk_sys(clk_sys),
    .rst(rst),
    .cfg(cfg_bus),
    .avg_shift(avg_shift),
    .bw_num(bw_num),
    .gain_x2(gain_x2),
    .afc_limit(afc_limit),
    .afc_limit_en(afc_limit_en)
  );
endmodule
`default_nettype wire

// >>> rtl/demod_param_decode.sv
// Purpose: turns raw configuration fields into datapath control values
// Assumes: fields come from the configuration bank
// Notes: registered outputs, one cycle behind the fields
`timescale 1ns/10ps
`default_nettype none
module demod_param_decode
  import demod_cfg_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset
  demod_cfg_if.user cfg, // raw configuration fields
  output logic [2:0] avg_shift, // log2 of averaging depth
  output logic [5:0] bw_num, // bandwidth factor numerator over 600
  output logic [3:0] gain_x2, // twice the detector gain
  output logic [7:0] afc_limit, // effective afc limit
  output logic afc_limit_en // limiter active
);
  typedef struct packed {
    logic [2:0] avg_shift;
    logic [5:0] bw_num;
    logic [3:0] gain_x2;
    logic [7:0] afc_limit;
    logic afc_limit_en;
  } dec_state_t;
  dec_state_t st, next_st;

  // combinational decode of the averaging, bandwidth, gain and afc fields
  always_comb begin
    next_st = st;
    case (cfg.post_detect_average)
      AVG_NONE: next_st.avg_shift = 3'h0;
      AVG_TWO: next_st.avg_shift = 3'h1;
      AVG_FOUR: next_st.avg_shift = 3'h2;
      AVG_EIGHT: next_st.avg_shift = 3'h3;
      default: next_st.avg_shift = 3'h0;
    endcase
    // factor times 600: 1/120, 1/100, 7/600, 1/75, 3/200, 1/60, 1/30
    case (cfg.detector_bandwidth_sel)
      3'h0: next_st.bw_num = 6'h05;
      3'h1: next_st.bw_num = 6'h06;
      3'h2: next_st.bw_num = 6'h07;
      3'h3: next_st.bw_num = 6'h08;
      3'h4: next_st.bw_num = 6'h09;
      3'h5: next_st.bw_num = 6'h0A;
      default: next_st.bw_num = 6'h14;
    endcase
    next_st.gain_x2 = {1'b0, cfg.detector_gain} + 4'h1;
    next_st.afc_limit_en = ~cfg.afc_limiter_disable;
    next_st.afc_limit = cfg.afc_limiter_disable ? 8'hFF : cfg.afc_track_range;
  end

  // register the decoded values
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign avg_shift = st.avg_shift;
  assign bw_num = st.bw_num;
  assign gain_x2 = st.gain_x2;
  assign afc_limit = st.afc_limit;
  assign afc_limit_en = st.afc_limit_en;
endmodule
`default_nettype wire

// >>> sim/demod_config_regs_props.sv
// Purpose: port assertions for the demodulator configuration bank
// Assumes: one clock, synchronous active-high reset
// Notes: decoded outputs trail their fields by one cycle
`timescale 1ns/10ps
`default_nettype none
module demod_config_regs_props
  import demod_cfg_pkg::*;
(
  input wire logic clk_sys, rst, reg_wr, reg_rd, afc_limiter_disable, reg_rvalid, afc_limit_en, // controls
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, four_level_threshold, rx_deviation_range, // bytes
  input wire logic [7:0] afc_track_range, synth_correction_coef, afc_limit, // bytes
  input wire logic [2:0] detector_bandwidth_sel, detector_gain, synth_correction_shift, avg_shift, // codes
  input wire logic [1:0] post_detect_average, // averaging code
  input wire logic [5:0] bw_num, // bandwidth numerator
  input wire logic [3:0] gain_x2 // twice gain
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_avg_decode: assert property (!$past(rst) |-> avg_shift == {1'b0, $past(post_detect_average)})
    else $error("averaging shift wrong");
  a_bw_decode: assert property (!$past(rst) |-> bw_num == (($past(detector_bandwidth_sel) > 3'h5) ? 6'h14 :
    6'($past(detector_bandwidth_sel)) + 6'h05)) else $error("bandwidth numerator wrong");
  a_gain_decode: assert property (!$past(rst) |-> gain_x2 == 4'($past(detector_gain)) + 4'h1)
    else $error("gain wrong");
  a_afc_limit: assert property (!$past(rst) |-> afc_limit == ($past(afc_limiter_disable) ? 8'hFF :
    $past(afc_track_range))) else $error("afc limit wrong");
  a_limit_enable: assert property (!$past(rst) |-> afc_limit_en == !$past(afc_limiter_disable))
    else $error("limiter enable wrong");
  a_read_pulse: assert property (!$past(rst) |-> reg_rvalid == $past(reg_rd))
    else $error("read valid wrong");
  a_rdata_idle: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
    else $error("read data not zero");
  a_thresh_write: assert property (reg_wr && reg_addr == OFS_THRESH |=> four_level_threshold == $past(reg_wdata))
    else $error("threshold not written");
  a_rxdev_write: assert property (reg_wr && reg_addr == OFS_RXDEV |=> rx_deviation_range == $past(reg_wdata))
    else $error("deviation range not written");
  a_shift_write: assert property (reg_wr && reg_addr == OFS_SHIFT |=>
    {5'h00, synth_correction_shift} == ($past(reg_wdata) & 8'h07)) else $error("shift not written");
  a_coef_readback: assert property (reg_rd && reg_addr == OFS_COEF |=>
    reg_rvalid && reg_rdata == $past(synth_correction_coef)) else $error("coefficient readback wrong");
  c_rsvd_read: cover property (reg_rd && reg_addr == OFS_RSVD_B);
  c_rd_wr: cover property (reg_wr && reg_rd);
  c_no_limit: cover property (afc_limiter_disable && reg_wr);
endmodule
bind demod_config_regs demod_config_regs_props demod_config_regs_props_i (.clk_sys, .rst, .reg_wr, .reg_rd,
  .afc_limiter_disable, .reg_rvalid, .afc_limit_en, .reg_addr, .reg_wdata, .reg_rdata, .four_level_threshold,
  .rx_deviation_range, .afc_track_range, .synth_correction_coef, .afc_limit, .detector_bandwidth_sel,
  .detector_gain, .synth_correction_shift, .avg_shift, .post_detect_average, .bw_num, .gain_x2);
`default_nettype wire

// >>> sim/tb_demod_config_regs.sv
// Purpose: self-checking bench for the demodulator configuration bank
// Assumes: read data answers one cycle after the strobe
// Notes: expected reads queue up and a monitor matches them
`timescale 1ns/10ps
`default_nettype none
module tb_demod_config_regs
  import demod_cfg_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, afc_limiter_disable = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0] reg_rdata, four_level_threshold, rx_deviation_range, afc_track_range, synth_correction_coef, afc_limit;
  logic [2:0] detector_bandwidth_sel, detector_gain, synth_correction_shift, avg_shift;
  logic [1:0] post_detect_average;
  logic [5:0] bw_num;
  logic [3:0] gain_x2;
  logic reg_rvalid, afc_limit_en;
  logic [7:0] mdl [256];
  logic [7:0] q [$];
  int error_cnt = 0, n_checks = 0;
  localparam logic [7:0] RV [9] = '{8'h04, 8'h01, 8'h14, 8'h00, 8'h00, 8'h12, 8'h0D, 8'h05, 8'h6C};
  demod_config_regs demod_config_regs_i (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .afc_limiter_disable, .reg_rdata, .reg_rvalid, .post_detect_average, .detector_bandwidth_sel, .detector_gain,
    .four_level_threshold, .rx_deviation_range, .afc_track_range, .synth_correction_shift, .synth_correction_coef,
    .avg_shift, .bw_num, .gain_x2, .afc_limit, .afc_limit_en);
  initial forever #2.5 clk_sys = ~clk_sys;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one access per cycle; expected read value noted before the write lands
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    if (r) q.push_back(mdl[a]);
    if (w && a >= OFS_FILTER && a <= OFS_COEF) mdl[a] = d;
    @(posedge clk_sys);
  endtask
  task automatic drain();
    op(1'b0, 1'b0, 8'h00, 8'h00);
    for (int k = 0; k < 4 && q.size() > 0; k++) @(posedge clk_sys);
    if (q.size() > 0) begin
      error_cnt++;
      summarize();
    end
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 256; i++) mdl[i] = (i >= 8'h57 && i <= 8'h5F) ? RV[i - 8'h57] : 8'h00;
    rst <= 1'b0;
  endtask
  task automatic read_all();
    for (int a = 8'h55; a < 8'h62; a++) op(1'b0, 1'b1, 8'(a), 8'h00);
    drain();
  endtask
  // fields and decoded values, after two quiet cycles
  task automatic chk_all();
    logic [7:0] f;
    repeat (2) op(1'b0, 1'b0, 8'h00, 8'h00);
    #1;
    f = mdl[OFS_FILTER];
    chk("fields", {f[5:4], f[2:0], mdl[OFS_GAIN][2:0], mdl[OFS_THRESH], mdl[OFS_RXDEV], mdl[OFS_AFCLIM],
      mdl[OFS_SHIFT][2:0], mdl[OFS_COEF]}, {post_detect_average, detector_bandwidth_sel, detector_gain,
      four_level_threshold, rx_deviation_range, afc_track_range, synth_correction_shift, synth_correction_coef});
    chk("decoded", {1'b0, f[5:4], ((f[2:0] > 3'h5) ? 6'h14 : 6'(f[2:0]) + 6'h05),
      4'(mdl[OFS_GAIN][2:0]) + 4'h1, (afc_limiter_disable ? 8'hFF : mdl[OFS_AFCLIM]), !afc_limiter_disable},
      {avg_shift, bw_num, gain_x2, afc_limit, afc_limit_en});
  endtask
  // read results matched against the oldest note
  always @(negedge clk_sys) begin
    if (reg_rvalid === 1'b1) begin
      if (q.size() == 0) chk("rvalid", 64'h0, 64'h1);
      else chk("rdata", 64'(q.pop_front()), 64'(reg_rdata));
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] r;
    void'($urandom(56338));
    do_reset();
    read_all();
    chk_all();
    // every averaging, bandwidth, gain and shift code, back to back
    for (int i = 0; i < 32; i++) begin
      r = 8'($urandom);
      afc_limiter_disable <= r[0];
      op(1'b1, 1'b0, OFS_FILTER, {r[7:6], i[4:3], r[3], i[2:0]});
      op(1'b1, 1'b0, OFS_GAIN, {r[7:3], i[2:0]});
      op(1'b1, 1'b0, OFS_SHIFT, {r[4:0], i[2:0]});
      op(1'b1, 1'b1, OFS_AFCLIM, r);
      chk_all();
    end
    // mixed traffic over mapped, reserved and unmapped offsets
    for (int i = 0; i < 400; i++) begin
      r = 8'($urandom);
      op(r[0], r[1], 8'h52 + 8'($urandom % 18), 8'($urandom));
    end
    // software loads its initialization set, the reset values stand in for it
    for (int k = 0; k < NUM_REGS; k++) op(1'b1, 1'b0, OFS_FILTER + 8'(k), RV[k]);
    drain();
    chk_all();
    read_all();
    do_reset();
    read_all();
    chk_all();
    summarize();
  end
endmodule
`default_nettype wire
